/* File: core/pmc_pkg.sv */
package pmc_pkg;

  // register map: printed offsets are indices, byte address is index * 4
  localparam logic [11:0] POWER_CONTROL_INDEX = 12'h087;
  localparam logic [11:0] STATUS_INDEX = 12'h088;
  localparam logic [11:0] POWER_CONTROL_ADDR = {POWER_CONTROL_INDEX[9:0], 2'h0};
  localparam logic [11:0] STATUS_ADDR = {STATUS_INDEX[9:0], 2'h0};

  // power_control field positions and reset value
  localparam int IDLE_ARM_POS = 0;
  localparam int PD_ARM_POS = 1;
  localparam int SLOW_POS = 4;
  localparam int IDLE_START_POS = 5;
  localparam int PD_START_POS = 6;
  localparam logic [7:0] POWER_CONTROL_RESET = 8'h00;

  // status register field positions
  localparam int ST_SLOW_POS = 0;
  localparam int ST_IDLE_POS = 1;
  localparam int ST_PD_POS = 2;
  localparam int ST_HARD_POWERDOWN_PIN_POS = 3;
  localparam int ST_BLOCK_PIN_POS = 4;
  localparam int ST_OSC_FLAG_POS = 5;

  // timing counts
  localparam int SLOW_DIV = 8;
  localparam int MC_CLKS = 12;
  localparam int HARD_POWERDOWN_PIN_RST_MCS = 2;

  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [5:0]
  {
    ST_RUN = 6'h01,
    ST_IDLE = 6'h02,
    ST_PD = 6'h04,
    ST_HARD_POWERDOWN_PIN_RST = 6'h08,
    ST_HARD_POWERDOWN_PIN_OFF = 6'h10,
    ST_HARD_POWERDOWN_PIN_START = 6'h20
  } pmc_state_t;

  typedef struct packed
  {
    logic cpu;
    logic periph;
    logic wdt;
    logic clkout;
  } pmc_clk_en_t;

  typedef struct packed
  {
    logic float_pins;
    logic hold_ports;
    logic addr_latch_high;
    logic prog_store_high;
  } pmc_pad_ctl_t;

endpackage

/* File: core/pmc_sync2.sv */
`timescale 1ns/1ns
// two-flop synchroniser for pin levels
module pmc_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta <= RESET_VAL;
      q <= RESET_VAL;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

/* File: core/pmc_cycle_divider.sv */
`timescale 1ns/1ns
// oscillator-rate enable, slowed by eight, and machine-cycle enable
module pmc_cycle_divider #(
  parameter int SLOW_DIV = pmc_pkg::SLOW_DIV,
  parameter int MC_CLKS = pmc_pkg::MC_CLKS
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic slow,
  output logic osc_tick,
  output logic mc_tick
);

  logic [3:0] div_cnt;
  logic [3:0] mc_cnt;
  wire div_end = (div_cnt == 4'(SLOW_DIV - 1));
  wire mc_end = (mc_cnt == 4'(MC_CLKS - 1));

  // every oscillator-derived rate is divided while slow
  assign osc_tick = run & (~slow | div_end);
  assign mc_tick = osc_tick & mc_end;

  // divider counters only move while the oscillator runs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_cnt <= 4'h0;
      mc_cnt <= 4'h0;
    end
    else if (run)
    begin
      div_cnt <= (div_end | ~slow) ? 4'h0 : div_cnt + 4'h1;
      if (osc_tick)
        mc_cnt <= mc_end ? 4'h0 : mc_cnt + 4'h1;
    end
  end

endmodule

/* File: core/pmc_power_mode_controller.sv */
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/1ns
module pmc_power_mode_controller (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic instr_done,
  input wire logic irq_pending,
  input wire logic save_block_autodog_pin,
  input wire logic hard_powerdown_pin_n,
  input wire logic osc_watchdog_enable_pin,
  input wire logic reset_pin_n,
  input wire logic main_osc_running,
  output pmc_pkg::pmc_clk_en_t clk_en,
  output pmc_pkg::pmc_pad_ctl_t pad_ctl,
  output logic main_osc_en,
  output logic rc_osc_en,
  output logic clk_from_rc,
  output logic internal_reset,
  output logic wdt_stop,
  output logic wdt_autostart,
  output logic idle_resume
);

  //////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [4:0] pins_s;
  logic block_s;
  logic hard_powerdown_pin_n_s;
  logic owe_s;
  logic rst_pin_n_s;
  logic osc_run_s;

  pmc_sync2 #(
    .W(5),
    .RESET_VAL(5'h1E)
  ) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({main_osc_running, reset_pin_n, osc_watchdog_enable_pin,
        hard_powerdown_pin_n, save_block_autodog_pin}),
    .q(pins_s)
  );

  // named views of synchronised pins
  assign block_s = pins_s[0];
  assign hard_powerdown_pin_n_s = pins_s[1];
  assign owe_s = pins_s[2];
  assign rst_pin_n_s = pins_s[3];
  assign osc_run_s = pins_s[4];

  //////////////////////////////////////////////////////////////////////////
  // state and control registers

  pmc_pkg::pmc_state_t state;
  pmc_pkg::pmc_state_t next_state;
  logic slow_sel;
  logic slow_active;
  logic idle_armed;
  logic pd_armed;
  logic [1:0] hard_powerdown_pin_cnt;
  logic osc_flag;
  logic int_rst_q;
  logic [1:0] settle;
  logic rst_hold;

  logic osc_tick;
  logic mc_tick;
  logic osc_on;

  // oscillator keeps running except in the stopped states
  assign osc_on = (state == pmc_pkg::ST_RUN) |
                  (state == pmc_pkg::ST_IDLE) |
                  (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_RST);

  pmc_cycle_divider #(
    .SLOW_DIV(pmc_pkg::SLOW_DIV),
    .MC_CLKS(pmc_pkg::MC_CLKS)
  ) u_div (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(osc_on),
    .slow(slow_active),
    .osc_tick(osc_tick),
    .mc_tick(mc_tick)
  );

  //////////////////////////////////////////////////////////////////////////
  // register bus decode

  function automatic logic is_addr(input logic [11:0] a,
                                   input logic [11:0] reg_addr);
    is_addr = ({a[11:2], 2'h0} == reg_addr);
  endfunction

  logic aw_hold;
  logic w_hold;
  logic [11:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  logic wr_power_control;
  logic wr_known;
  logic [7:0] wd;
  logic rd_take;
  logic [31:0] rd_mux;
  logic rd_known;
  logic [7:0] power_control_view;
  logic [7:0] status_view;
  logic hard_powerdown_pin_any;

  // write completes once both address and data are held
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;
  assign wr_known = is_addr(aw_addr_q, pmc_pkg::POWER_CONTROL_ADDR) |
                    is_addr(aw_addr_q, pmc_pkg::STATUS_ADDR);
  assign wr_power_control = do_write & w_strb_q[0] &
                   is_addr(aw_addr_q, pmc_pkg::POWER_CONTROL_ADDR) &
                   ~internal_reset;
  assign wd = w_data_q[7:0];
  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign rd_take = s_axi_arvalid & s_axi_arready;

  // arm and start bits read back as zero once used
  assign power_control_view = ({7'h00, idle_armed} << pmc_pkg::IDLE_ARM_POS) |
                     ({7'h00, pd_armed} << pmc_pkg::PD_ARM_POS) |
                     ({7'h00, slow_sel} << pmc_pkg::SLOW_POS);
  assign status_view =
    ({7'h00, slow_active} << pmc_pkg::ST_SLOW_POS) |
    ({7'h00, state == pmc_pkg::ST_IDLE} << pmc_pkg::ST_IDLE_POS) |
    ({7'h00, state == pmc_pkg::ST_PD} << pmc_pkg::ST_PD_POS) |
    ({7'h00, hard_powerdown_pin_any} << pmc_pkg::ST_HARD_POWERDOWN_PIN_POS) |
    ({7'h00, block_s} << pmc_pkg::ST_BLOCK_PIN_POS) |
    ({7'h00, osc_flag} << pmc_pkg::ST_OSC_FLAG_POS);
  assign rd_known = is_addr(s_axi_araddr, pmc_pkg::POWER_CONTROL_ADDR) |
                    is_addr(s_axi_araddr, pmc_pkg::STATUS_ADDR);
  assign rd_mux =
    is_addr(s_axi_araddr, pmc_pkg::POWER_CONTROL_ADDR) ? {24'h00_0000, power_control_view} :
    is_addr(s_axi_araddr, pmc_pkg::STATUS_ADDR) ?
      {24'h00_0000, status_view} : 32'h0000_0000;

  // write channel holding registers and response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr_q <= 12'h000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pmc_pkg::RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? pmc_pkg::RESP_OKAY
                                : pmc_pkg::RESP_SLVERR;
      end
      else if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read channel answers one cycle after the address is taken
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= pmc_pkg::RESP_OKAY;
    end
    else if (rd_take)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_known ? pmc_pkg::RESP_OKAY : pmc_pkg::RESP_SLVERR;
    end
    else if (s_axi_rvalid & s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // software entry sequences

  logic sw_allowed;
  logic idle_go;
  logic pd_go;
  logic rst_pin_act;

  assign sw_allowed = ~block_s;
  assign idle_go = wr_power_control & wd[pmc_pkg::IDLE_START_POS] & idle_armed &
                   sw_allowed & (state == pmc_pkg::ST_RUN);
  assign pd_go = wr_power_control & wd[pmc_pkg::PD_START_POS] & pd_armed &
                 sw_allowed & (state == pmc_pkg::ST_RUN);
  assign hard_powerdown_pin_any = (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_RST) |
                    (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_OFF) |
                    (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_START);
  assign rst_pin_act = ~rst_pin_n_s;

  // arm flags live for one instruction; the start write clears them
  always_ff @(posedge aclk)
  begin
    if (!aresetn || internal_reset)
    begin
      idle_armed <= pmc_pkg::POWER_CONTROL_RESET[pmc_pkg::IDLE_ARM_POS];
      pd_armed <= pmc_pkg::POWER_CONTROL_RESET[pmc_pkg::PD_ARM_POS];
      slow_sel <= pmc_pkg::POWER_CONTROL_RESET[pmc_pkg::SLOW_POS];
    end
    else if (wr_power_control)
    begin
      idle_armed <= wd[pmc_pkg::IDLE_ARM_POS] &
                    ~wd[pmc_pkg::IDLE_START_POS];
      pd_armed <= wd[pmc_pkg::PD_ARM_POS] &
                  ~wd[pmc_pkg::PD_START_POS];
      slow_sel <= wd[pmc_pkg::SLOW_POS];
    end
    else if (instr_done)
    begin
      idle_armed <= 1'b0;
      pd_armed <= 1'b0;
    end
  end

  // slow-down follows the control bit at a machine-cycle boundary
  always_ff @(posedge aclk)
  begin
    if (!aresetn || internal_reset)
      slow_active <= 1'b0;
    else if (mc_tick)
      slow_active <= slow_sel & sw_allowed;
  end

  //////////////////////////////////////////////////////////////////////////
  // mode sequencer

  always_comb
  begin
    next_state = state;
    case (state)
      pmc_pkg::ST_RUN:
      begin
        if (mc_tick & ~hard_powerdown_pin_n_s & ~rst_pin_act)
          next_state = pmc_pkg::ST_HARD_POWERDOWN_PIN_RST;
        else if (pd_go)
          next_state = pmc_pkg::ST_PD;
        else if (idle_go)
          next_state = pmc_pkg::ST_IDLE;
      end
      pmc_pkg::ST_IDLE:
      begin
        if (rst_pin_act)
          next_state = pmc_pkg::ST_RUN;
        else if (mc_tick & ~hard_powerdown_pin_n_s)
          next_state = pmc_pkg::ST_HARD_POWERDOWN_PIN_RST;
        else if (irq_pending)
          next_state = pmc_pkg::ST_RUN;
      end
      pmc_pkg::ST_PD:
      begin
        if (rst_pin_act)
          next_state = pmc_pkg::ST_RUN;
      end
      pmc_pkg::ST_HARD_POWERDOWN_PIN_RST:
      begin
        if (rst_pin_act)
          next_state = pmc_pkg::ST_RUN;
        else if (mc_tick && hard_powerdown_pin_cnt == 2'(pmc_pkg::HARD_POWERDOWN_PIN_RST_MCS - 1))
          next_state = pmc_pkg::ST_HARD_POWERDOWN_PIN_OFF;
      end
      pmc_pkg::ST_HARD_POWERDOWN_PIN_OFF:
      begin
        if (rst_pin_act)
          next_state = pmc_pkg::ST_RUN;
        else if (hard_powerdown_pin_n_s)
          next_state = pmc_pkg::ST_HARD_POWERDOWN_PIN_START;
      end
      pmc_pkg::ST_HARD_POWERDOWN_PIN_START:
      begin
        if (rst_pin_act || osc_run_s)
          next_state = pmc_pkg::ST_RUN;
      end
      default:
        next_state = pmc_pkg::ST_RUN;
    endcase
  end

  // state register, internal reset counter and idle wake pulse
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= pmc_pkg::ST_RUN;
      hard_powerdown_pin_cnt <= 2'h0;
      idle_resume <= 1'b0;
    end
    else
    begin
      state <= next_state;
      idle_resume <= (state == pmc_pkg::ST_IDLE) &
                     (next_state == pmc_pkg::ST_RUN) & ~rst_pin_act;
      if (state != pmc_pkg::ST_HARD_POWERDOWN_PIN_RST)
        hard_powerdown_pin_cnt <= 2'h0;
      else if (mc_tick)
        hard_powerdown_pin_cnt <= hard_powerdown_pin_cnt + 2'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // reset, watchdog and oscillator watchdog flag

  // pin reset acts at once; two machine cycles of pin hold suffice
  assign internal_reset = rst_pin_act |
                          (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_RST) |
                          (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_START);
  assign wdt_stop = internal_reset;

  // pin views need two edges after aresetn, so count that as reset too
  assign rst_hold = internal_reset | ~settle[1];

  // autostart only at reset release, never on later pin changes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      settle <= 2'h0;
      int_rst_q <= 1'b1;
      wdt_autostart <= 1'b0;
    end
    else
    begin
      settle <= {settle[0], 1'b1};
      int_rst_q <= rst_hold;
      wdt_autostart <= int_rst_q & ~rst_hold & block_s;
    end
  end

  // set on oscillator loss while running, cleared by start-up release
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      osc_flag <= 1'b0;
    else if (state == pmc_pkg::ST_RUN && !osc_run_s && owe_s)
      osc_flag <= 1'b1;
    else if (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_START && osc_run_s)
      osc_flag <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////
  // clock enables, oscillators and pads

  assign clk_en.cpu = osc_tick & (state == pmc_pkg::ST_RUN);
  assign clk_en.periph = osc_tick & (state != pmc_pkg::ST_HARD_POWERDOWN_PIN_RST) &
                         ((state == pmc_pkg::ST_RUN) |
                          (state == pmc_pkg::ST_IDLE));
  assign clk_en.wdt = osc_tick & (state == pmc_pkg::ST_RUN);
  assign clk_en.clkout = osc_tick;

  // both oscillators stop in power-down and in the hardware power-down off state
  assign main_osc_en = (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_START) ? owe_s :
                       osc_on;
  assign rc_osc_en = owe_s & (state != pmc_pkg::ST_PD) &
                     (state != pmc_pkg::ST_HARD_POWERDOWN_PIN_OFF);
  assign clk_from_rc = (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_START);

  assign pad_ctl.float_pins = (state == pmc_pkg::ST_HARD_POWERDOWN_PIN_OFF);
  assign pad_ctl.hold_ports = (state == pmc_pkg::ST_IDLE) |
                              (state == pmc_pkg::ST_PD);
  assign pad_ctl.addr_latch_high = (state == pmc_pkg::ST_IDLE);
  assign pad_ctl.prog_store_high = (state == pmc_pkg::ST_IDLE);

endmodule

/* File: tb/pmc_checker_sva.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// watches the mode outputs against their causes
module pmc_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic irq_pending,
  input wire logic reset_pin_n,
  input wire pmc_pkg::pmc_clk_en_t clk_en,
  input wire pmc_pkg::pmc_pad_ctl_t pad_ctl,
  input wire logic main_osc_en,
  input wire logic rc_osc_en,
  input wire logic clk_from_rc,
  input wire logic internal_reset,
  input wire logic wdt_stop,
  input wire logic wdt_autostart,
  input wire logic idle_resume
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  // cpu and watchdog clocks only while not frozen
  a_cpu_gated: assert property (clk_en.cpu |-> !pad_ctl.hold_ports)
    else $error("cpu clock runs while ports are held");
  a_wdt_gated: assert property (
    pad_ctl.addr_latch_high |-> !clk_en.wdt)
    else $error("watchdog clock runs in idle");
  a_idle_strobes: assert property (
    pad_ctl.hold_ports && main_osc_en && !pad_ctl.float_pins
    |-> pad_ctl.addr_latch_high && pad_ctl.prog_store_high)
    else $error("strobes not high in idle");
  a_float_osc: assert property (
    pad_ctl.float_pins |-> !main_osc_en && !rc_osc_en)
    else $error("pins float with an oscillator on");
  a_wdt_stop: assert property (internal_reset |-> wdt_stop)
    else $error("watchdog not stopped in reset");
  a_autostart_out: assert property (
    wdt_autostart |-> !internal_reset ##1 !wdt_autostart)
    else $error("autostart inside reset or too long");
  a_idle_resume: assert property (
    idle_resume |-> ($past(irq_pending) || $past(irq_pending, 2))
    && !pad_ctl.hold_ports)
    else $error("resume without interrupt");
  a_rc_reset: assert property (
    clk_from_rc |-> internal_reset && rc_osc_en)
    else $error("rc clock outside start-up reset");
  a_reset_pin: assert property (
    !reset_pin_n [*5] |-> internal_reset && !pad_ctl.float_pins)
    else $error("reset pin not obeyed");
endmodule

bind pmc_power_mode_controller pmc_checker u_chk (
  .aclk(aclk), .aresetn(aresetn), .irq_pending(irq_pending),
  .reset_pin_n(reset_pin_n), .clk_en(clk_en), .pad_ctl(pad_ctl),
  .main_osc_en(main_osc_en), .rc_osc_en(rc_osc_en),
  .clk_from_rc(clk_from_rc), .internal_reset(internal_reset),
  .wdt_stop(wdt_stop), .wdt_autostart(wdt_autostart),
  .idle_resume(idle_resume)
);

/* File: tb/pmc_osc_model.sv */
`timescale 1ns/1ns
////////////////////////////////////////////////////////////
// main oscillator: runs a set number of cycles after enable
module pmc_osc_model (
  input wire logic aclk,
  input wire logic en,
  input wire logic [7:0] start_cycles,
  output logic running
);
  logic [7:0] cnt = 8'h00;
  logic run_q = 1'h0;
  assign running = run_q;
  // stops dead when disabled, starts slowly when enabled
  always @(posedge aclk)
  begin
    if (!en)
    begin
      cnt <= 8'h00;
      run_q <= 1'h0;
    end
    else if (cnt == start_cycles)
      run_q <= 1'h1;
    else
      cnt <= cnt + 8'h01;
  end
endmodule

/* File: tb/tb_power_mode_controller.sv */
`timescale 1ns/1ns
module tb_power_mode_controller;
  localparam logic [11:0] PC = pmc_pkg::POWER_CONTROL_ADDR;
  localparam logic [11:0] ST = pmc_pkg::STATUS_ADDR;
  localparam int F_OUT = 0, F_WDT = 1, F_PER = 2, F_CPU = 3;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, instr_done;
  logic irq_pending, save_block_autodog_pin, hard_powerdown_pin_n;
  logic osc_watchdog_enable_pin, reset_pin_n, main_osc_running;
  logic main_osc_en, rc_osc_en, clk_from_rc, internal_reset;
  logic wdt_stop, wdt_autostart, idle_resume;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [7:0] osc_delay;
  pmc_pkg::pmc_clk_en_t clk_en;
  pmc_pkg::pmc_pad_ctl_t pad_ctl;
  int n_fail = 0, total_checks = 0, cyc = 0, c;

  pmc_power_mode_controller u_dut (.*);
  pmc_osc_model u_osc (.aclk(aclk), .en(main_osc_en),
    .start_cycles(osc_delay), .running(main_osc_running));
  ////////////////////////////////////////////////////////////
  // shared helpers
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // one register write, address and data offered together
  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h00_0000, d};
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'h0;
      if (s_axi_wready) s_axi_wvalid <= 1'h0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'h0;
  endtask

  task automatic axr(input logic [11:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'h0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  task automatic stat(input int p, input logic e);
    axr(ST);
    chk(rd[p], e);
  endtask

  // counts pulses of one clock enable over n cycles
  task automatic cnt(input int n, input int f);
    c = 0;
    repeat (n)
    begin
      @(posedge aclk);
      if (clk_en[f] === 1'h1) c++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs;
    axr(PC);
    chk(rd, {24'h00_0000, pmc_pkg::POWER_CONTROL_RESET});
    axr(12'h400);
    chk(rr, pmc_pkg::RESP_SLVERR);
  endtask

  task automatic t_slow;
    axw(PC, 8'h10);
    tick(2 * pmc_pkg::MC_CLKS);
    cnt(80, F_OUT);
    chk(c, 10);
    cnt(80, F_WDT);
    chk(c, 10);
    stat(pmc_pkg::ST_SLOW_POS, 1'h1);
    axw(PC, 8'h00);
    tick(2 * pmc_pkg::MC_CLKS * pmc_pkg::SLOW_DIV);
    cnt(80, F_OUT);
    chk(c, 80);
  endtask

  task automatic t_idle;
    axw(PC, 8'h01);
    axw(PC, 8'h20);
    stat(pmc_pkg::ST_IDLE_POS, 1'h1);
    cnt(40, F_CPU);
    chk(c, 0);
    cnt(40, F_WDT);
    chk(c, 0);
    cnt(40, F_PER);
    chk(c, 40);
    chk(pad_ctl, 4'h7);
    irq_pending <= 1'h1;
    repeat (8) if (idle_resume !== 1'h1) @(posedge aclk);
    chk(idle_resume, 1'h1);
    irq_pending <= 1'h0;
    stat(pmc_pkg::ST_IDLE_POS, 1'h0);
  endtask

  task automatic t_noarm;
    axw(PC, 8'h20);
    stat(pmc_pkg::ST_IDLE_POS, 1'h0);
    axw(PC, 8'h40);
    stat(pmc_pkg::ST_PD_POS, 1'h0);
    axw(PC, 8'h01);
    @(posedge aclk);
    instr_done <= 1'h1;
    @(posedge aclk);
    instr_done <= 1'h0;
    axw(PC, 8'h20);
    stat(pmc_pkg::ST_IDLE_POS, 1'h0);
  endtask

  task automatic t_block;
    save_block_autodog_pin <= 1'h1;
    tick(4);
    axw(PC, 8'h02);
    axw(PC, 8'h40);
    stat(pmc_pkg::ST_PD_POS, 1'h0);
    axw(PC, 8'h10);
    tick(30);
    stat(pmc_pkg::ST_SLOW_POS, 1'h0);
    cnt(20, F_WDT);
    chk(c, 20);
    axw(PC, 8'h00);
    save_block_autodog_pin <= 1'h0;
    tick(4);
  endtask

  task automatic t_pd;
    axw(PC, 8'h02);
    axw(PC, 8'h40);
    axr(PC);
    chk(rd & 32'h0000_0042, 32'h0000_0000);
    stat(pmc_pkg::ST_PD_POS, 1'h1);
    chk({main_osc_en, rc_osc_en}, 2'h0);
    irq_pending <= 1'h1;
    tick(20);
    stat(pmc_pkg::ST_PD_POS, 1'h1);
    irq_pending <= 1'h0;
    reset_pin_n <= 1'h0;
    tick(6);
    reset_pin_n <= 1'h1;
    tick(20);
    stat(pmc_pkg::ST_PD_POS, 1'h0);
  endtask

  task automatic t_rst;
    axw(PC, 8'h01);
    axw(PC, 8'h20);
    reset_pin_n <= 1'h0;
    tick(2 * pmc_pkg::MC_CLKS);
    chk({internal_reset, pad_ctl}, 5'h10);
    chk(idle_resume, 1'h0);
    reset_pin_n <= 1'h1;
    tick(4);
    save_block_autodog_pin <= 1'h1;
    tick(4);
    stat(pmc_pkg::ST_IDLE_POS, 1'h0);
    aresetn <= 1'h0;
    tick(3);
    aresetn <= 1'h1;
    repeat (6) if (wdt_autostart !== 1'h1) @(posedge aclk);
    chk(wdt_autostart, 1'h1);
    save_block_autodog_pin <= 1'h0;
    tick(4);
  endtask

  task automatic t_hard_powerdown_pin;
    save_block_autodog_pin <= 1'h1;
    hard_powerdown_pin_n <= 1'h0;
    repeat (40) if (internal_reset !== 1'h1) @(posedge aclk);
    chk({internal_reset, wdt_stop}, 2'h3);
    repeat (40) if (pad_ctl.float_pins !== 1'h1) @(posedge aclk);
    chk({pad_ctl.float_pins, main_osc_en, rc_osc_en}, 3'h4);
    tick(30);
    chk(pad_ctl.float_pins, 1'h1);
    osc_delay <= 8'h1e;
    hard_powerdown_pin_n <= 1'h1;
    repeat (20) if (clk_from_rc !== 1'h1) @(posedge aclk);
    chk({clk_from_rc, internal_reset, pad_ctl.float_pins}, 3'h6);
    repeat (80) if (internal_reset !== 1'h0) @(posedge aclk);
    chk(internal_reset, 1'h0);
    repeat (3) if (wdt_autostart !== 1'h1) @(posedge aclk);
    chk(wdt_autostart, 1'h1);
    stat(pmc_pkg::ST_OSC_FLAG_POS, 1'h0);
  endtask
  ////////////////////////////////////////////////////////////
  // clock, timeout and main sequence
  initial
  begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  always @(posedge aclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      report_and_stop;
    end
  end

  initial
  begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, instr_done, irq_pending} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    save_block_autodog_pin = 1'h0;
    hard_powerdown_pin_n = 1'h1;
    osc_watchdog_enable_pin = 1'h1;
    reset_pin_n = 1'h1;
    osc_delay = 8'h03;
    tick(20);
    aresetn <= 1'h1;
    tick(4);
    t_regs;
    t_slow;
    t_idle;
    t_noarm;
    t_block;
    t_pd;
    t_rst;
    t_hard_powerdown_pin;
    report_and_stop;
  end
endmodule
